// >>> hw/mpds_params.svh
// Constants of the metering pump dispense sequencer: offsets, resets, timing.
// Assumes a 40 MHz system clock; included by bare name from the design modules.
`ifndef MPDS_PARAMS_SVH
`define MPDS_PARAMS_SVH

`define MPDS_CLK_HZ         40000000
`define MPDS_STEPS_PER_REV  200
`define MPDS_STALL_MARGIN   8
`define MPDS_STALL_LIMIT    (`MPDS_STEPS_PER_REV + `MPDS_STALL_MARGIN)
`define MPDS_SETTING_MAX    10'h3e7
`define MPDS_COUNT_RST      10'h001
`define MPDS_SPEED_RST      10'h1f4
`define MPDS_FULL_SCALE     1000
`define MPDS_MAX_SPS        3333
`define MPDS_ACC_MOD        (64'h1 * `MPDS_CLK_HZ * `MPDS_FULL_SCALE / `MPDS_MAX_SPS)
`define MPDS_RAMP_US        1000
`define MPDS_RAMP_CYC       (`MPDS_RAMP_US * (`MPDS_CLK_HZ / 1000000))

`define MPDS_ADDR_CTRL      4'h0
`define MPDS_ADDR_STATUS    4'h1
`define MPDS_ADDR_REVS      4'h2
`define MPDS_ADDR_COUNT_SET 4'h3
`define MPDS_ADDR_SPEED_SET 4'h4
`define MPDS_CTRL_CLR_STALL 0

`endif

// >>> hw/mpds_pkg.sv
// Types of the metering pump dispense sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package mpds_pkg;

    localparam int ACC_W   = 25;
    localparam int PANEL_W = 11;

    typedef logic [9:0] mpds_setting_t;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_RUN      = 6'h02,
        ST_STOP     = 6'h04,
        ST_RETRACT  = 6'h08,
        ST_RET_STOP = 6'h10,
        ST_STALL    = 6'h20
    } mpds_state_t;

    // Front panel, trigger and spindle sensor pins; all asynchronous
    typedef struct packed {
        logic dispense_or_continuous_select;
        logic flow_direction_select;
        logic retract_mode_select;
        logic run_press;
        logic halt_press;
        logic count_plus;
        logic count_minus;
        logic speed_plus;
        logic speed_minus;
        logic contact_closure_trigger_input;
        logic spindle_pulse;
    } mpds_panel_t;

    typedef struct packed {
        logic dispense_lamp;
        logic continuous_lamp;
        logic forward_lamp;
        logic reverse_lamp;
        logic normal_lamp;
        logic retract_lamp;
        logic run_lamp;
        logic halt_lamp;
    } mpds_lamp_t;

endpackage

// >>> hw/mpds_step_gen.sv
// Step rate generator with linear acceleration and deceleration ramps.
// Assumes run and target come from logic on the same clock.
`timescale 1ns/1ps
`include "mpds_params.svh"

module mpds_step_gen #(
    parameter int unsigned RAMP_TICK_CYCLES = `MPDS_RAMP_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    run,
    input  wire mpds_pkg::mpds_setting_t target,
    output logic                         step,
    output logic                         moving
);
    import mpds_pkg::*;

    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(`MPDS_ACC_MOD);

    logic [31:0]      ramp_cnt;
    logic             ramp_tick;
    mpds_setting_t    cur_rate;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;

    assign ramp_tick = (ramp_cnt == 32'(RAMP_TICK_CYCLES - 1));
    assign next_acc  = acc + ACC_W'(cur_rate);

    always_ff @(posedge clk) begin
        if (rst || ramp_tick) begin
            ramp_cnt <= 32'h0;
        end else begin
            ramp_cnt <= ramp_cnt + 32'h1;
        end
    end

    // One count per tick: full speed is reached gradually, never abruptly
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_rate <= 10'h000;
        end else if (ramp_tick) begin
            if (run && cur_rate < target) begin
                cur_rate <= cur_rate + 10'h001;
            end else if ((!run || cur_rate > target) && cur_rate != 10'h000) begin
                cur_rate <= cur_rate - 10'h001;
            end
        end
    end

    // Phase accumulator: step period is inverse to the rate, zero rate never steps
    always_ff @(posedge clk) begin
        if (rst) begin
            acc  <= '0;
            step <= 1'b0;
        end else if (cur_rate == 10'h000) begin
            acc  <= '0;
            step <= 1'b0;
        end else if (next_acc >= ACC_MOD) begin
            acc  <= next_acc - ACC_MOD;
            step <= 1'b1;
        end else begin
            acc  <= next_acc;
            step <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            moving <= 1'b0;
        end else begin
            moving <= (cur_rate != 10'h000);
        end
    end

endmodule

// >>> hw/mpds_top.sv
// Metering pump dispense sequencer: panel, trigger, spindle counting, stepper control.
// Assumes asynchronous panel pins and a same-clock register master.
//
// Functional notes
// - Select input picks counted dispense or continuous running.
// - Flow direction select sets motor rotation direction.
// - Lamps show the active side of mode and direction selects.
// - Run press starts pump operation; halt press stops it.
// - Green run lamp after run, red halt lamp after halt, held.
// - Retract mode select chooses normal or retract, with lamps.
// - Rotation count setting, 000 to 999, gives revolutions per cycle.
// - Plus raises a setting by one, minus lowers it by one.
// - Stepping speed proportional to speed setting, 0.1 percent per count.
// - External trigger input starts operation like a run press.
// - Count spindle pulses; decelerate when count reaches the setting.
// - Ramp stepping rate up at start and down before stop.
// - Trigger acts on its rising edge only; length is irrelevant.
// - Stall when over 200 steps plus margin pass without spindle pulse.
// - Continuous runs until halt; switching to dispense adds counted revolutions.
// - In retract mode, reverse until the next spindle pulse after each completed dispense.
`timescale 1ns/1ps
`include "mpds_params.svh"

module mpds_top #(
    parameter int unsigned RAMP_TICK_CYCLES = `MPDS_RAMP_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire mpds_pkg::mpds_panel_t panel,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [15:0]               reg_rdata,
    output logic                      step_pulse,
    output logic                      motor_dir,
    output mpds_pkg::mpds_lamp_t      lamps,
    output logic                      stall_fault,
    output logic                      busy
);
    import mpds_pkg::*;

    localparam logic [8:0] STALL_LIMIT = 9'(`MPDS_STALL_LIMIT);

    logic [PANEL_W-1:0] pin_raw;
    logic [PANEL_W-1:0] sync1;
    logic [PANEL_W-1:0] sync2;
    logic [PANEL_W-1:0] prev;
    mpds_panel_t        pin_now;
    mpds_panel_t        pin_rise;

    mpds_setting_t      rotation_count_setting;
    mpds_setting_t      speed_setting;
    mpds_setting_t      rev_count;
    mpds_state_t        state;
    logic               retract_due;
    logic               dir_latch;
    logic [8:0]         steps_since_rev;
    logic               stall_hit;
    logic               start_evt;
    logic               halt_evt;
    logic               run_req;
    logic               moving;
    logic               counting;
    logic               count_done;
    logic               continuous;
    logic               clr_stall;

    assign pin_raw = panel;

    // Three flops per pin; edge detection reads the second and third stages
    genvar gi;
    generate
        for (gi = 0; gi < PANEL_W; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    prev[gi]  <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    prev[gi]  <= sync2[gi];
                end
            end
        end
    endgenerate

    assign pin_now  = mpds_panel_t'(sync2);
    assign pin_rise = mpds_panel_t'(sync2 & ~prev);

    // Halt wins over a start arriving in the same cycle
    assign halt_evt   = pin_rise.halt_press;
    assign start_evt  = (pin_rise.run_press
                       | pin_rise.contact_closure_trigger_input)
                       & ~halt_evt;
    assign continuous = pin_now.dispense_or_continuous_select;
    assign counting   = (state == ST_RUN) && !continuous;
    assign count_done = counting && (rev_count >= rotation_count_setting);
    assign stall_hit  = (steps_since_rev > STALL_LIMIT);
    assign run_req    = (state == ST_RUN) || (state == ST_RETRACT);
    assign clr_stall  = reg_wr && (reg_addr == `MPDS_ADDR_CTRL)
                        && reg_wdata[`MPDS_CTRL_CLR_STALL];

    // Settings saturate at both ends of 000..999
    always_ff @(posedge clk) begin
        if (rst) begin
            rotation_count_setting <= `MPDS_COUNT_RST;
        end else if (pin_rise.count_plus && rotation_count_setting < `MPDS_SETTING_MAX) begin
            rotation_count_setting <= rotation_count_setting + 10'h001;
        end else if (pin_rise.count_minus && rotation_count_setting != 10'h000) begin
            rotation_count_setting <= rotation_count_setting - 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            speed_setting <= `MPDS_SPEED_RST;
        end else if (pin_rise.speed_plus && speed_setting < `MPDS_SETTING_MAX) begin
            speed_setting <= speed_setting + 10'h001;
        end else if (pin_rise.speed_minus && speed_setting != 10'h000) begin
            speed_setting <= speed_setting - 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_evt) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (halt_evt) begin
                        state <= ST_STOP;
                    end else if (stall_hit) begin
                        state <= ST_STALL;
                    end else if (count_done) begin
                        state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (!moving) begin
                        state <= retract_due ? ST_RETRACT : ST_IDLE;
                    end
                end
                ST_RETRACT: begin
                    if (halt_evt || pin_rise.spindle_pulse) begin
                        state <= ST_RET_STOP;
                    end else if (stall_hit) begin
                        state <= ST_STALL;
                    end
                end
                ST_RET_STOP: begin
                    if (!moving) begin
                        state <= ST_IDLE;
                    end
                end
                ST_STALL: begin
                    if (!moving) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Retract follows only a completed count, sampled at that moment
    always_ff @(posedge clk) begin
        if (rst) begin
            retract_due <= 1'b0;
        end else if (state == ST_RUN && !halt_evt && !stall_hit && count_done) begin
            retract_due <= pin_now.retract_mode_select;
        end else if (halt_evt || state == ST_IDLE || state == ST_RETRACT) begin
            retract_due <= 1'b0;
        end
    end

    // Continuous running holds the count at zero, so a switch to dispense counts afresh
    always_ff @(posedge clk) begin
        if (rst) begin
            rev_count <= 10'h000;
        end else if (state == ST_IDLE || (state == ST_RUN && continuous)) begin
            rev_count <= 10'h000;
        end else if (counting && pin_rise.spindle_pulse && rev_count != 10'h3ff) begin
            rev_count <= rev_count + 10'h001;
        end
    end

    // Steps since the last spindle pulse; decel steps count too
    always_ff @(posedge clk) begin
        if (rst) begin
            steps_since_rev <= 9'h000;
        end else if (state == ST_IDLE || pin_rise.spindle_pulse) begin
            steps_since_rev <= 9'h000;
        end else if (step_pulse && steps_since_rev != 9'h1ff) begin
            steps_since_rev <= steps_since_rev + 9'h001;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            stall_fault <= 1'b0;
        end else if (run_req && stall_hit) begin
            stall_fault <= 1'b1;
        end else if (clr_stall || halt_evt) begin
            stall_fault <= 1'b0;
        end
    end

    // Direction is only taken at standstill; a stall during retract restores dir_latch while the drive still decelerates
    always_ff @(posedge clk) begin
        if (rst) begin
            dir_latch <= 1'b0;
            motor_dir <= 1'b0;
        end else begin
            if (state == ST_IDLE) begin
                dir_latch <= pin_now.flow_direction_select;
            end
            if (state == ST_RETRACT || state == ST_RET_STOP) begin
                motor_dir <= ~dir_latch;
            end else begin
                motor_dir <= dir_latch;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lamps.dispense_lamp   <= 1'b0;
            lamps.continuous_lamp <= 1'b0;
            lamps.forward_lamp    <= 1'b0;
            lamps.reverse_lamp    <= 1'b0;
            lamps.normal_lamp     <= 1'b0;
            lamps.retract_lamp    <= 1'b0;
        end else begin
            lamps.dispense_lamp   <= ~pin_now.dispense_or_continuous_select;
            lamps.continuous_lamp <= pin_now.dispense_or_continuous_select;
            lamps.forward_lamp    <= ~pin_now.flow_direction_select;
            lamps.reverse_lamp    <= pin_now.flow_direction_select;
            lamps.normal_lamp     <= ~pin_now.retract_mode_select;
            lamps.retract_lamp    <= pin_now.retract_mode_select;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lamps.run_lamp  <= 1'b0;
            lamps.halt_lamp <= 1'b1;
        end else if (halt_evt) begin
            lamps.run_lamp  <= 1'b0;
            lamps.halt_lamp <= 1'b1;
        end else if (start_evt) begin
            lamps.run_lamp  <= 1'b1;
            lamps.halt_lamp <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != ST_IDLE);
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_addr)
                `MPDS_ADDR_STATUS: begin
                    reg_rdata <= {6'h00, 1'b0, state, moving, motor_dir, stall_fault};
                end
                `MPDS_ADDR_REVS: begin
                    reg_rdata <= {6'h00, rev_count};
                end
                `MPDS_ADDR_COUNT_SET: begin
                    reg_rdata <= {6'h00, rotation_count_setting};
                end
                `MPDS_ADDR_SPEED_SET: begin
                    reg_rdata <= {6'h00, speed_setting};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end
    end

    mpds_step_gen #(
        .RAMP_TICK_CYCLES (RAMP_TICK_CYCLES)
    ) u_step_gen (
        .clk    (clk),
        .rst    (rst),
        .run    (run_req),
        .target (speed_setting),
        .step   (step_pulse),
        .moving (moving)
    );

endmodule

// >>> dv/mpds_monitor.sv
// Checker for the dispense sequencer top: bus, lamps, start and stepping.
// Assumes binding onto mpds_top, one clock, synchronous active-high rst.
`timescale 1ns/1ps
module mpds_monitor #(
    parameter int unsigned RAMP_TICK_CYCLES = 40000
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire mpds_pkg::mpds_panel_t panel,
    input wire logic [3:0]            reg_addr,
    input wire logic [15:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [15:0]           reg_rdata,
    input wire logic                  step_pulse,
    input wire logic                  motor_dir,
    input wire mpds_pkg::mpds_lamp_t  lamps,
    input wire logic                  stall_fault,
    input wire logic                  busy
);
    import mpds_pkg::*;
    // Edges since reset release; lamp checks wait out the sync pipeline
    logic [2:0] up_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    a_rdata_unmapped: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_mode_lamps: assert property (up_cnt > 3'h3 |->
        lamps.continuous_lamp == $past(panel.dispense_or_continuous_select, 3)
        && lamps.dispense_lamp != lamps.continuous_lamp) else $error("mode lamps wrong");
    a_dir_lamps: assert property (up_cnt > 3'h3 |->
        lamps.reverse_lamp == $past(panel.flow_direction_select, 3)
        && lamps.forward_lamp != lamps.reverse_lamp) else $error("direction lamps wrong");
    a_retract_lamps: assert property (up_cnt > 3'h3 |->
        lamps.retract_lamp == $past(panel.retract_mode_select, 3)
        && lamps.normal_lamp != lamps.retract_lamp) else $error("retract lamps wrong");
    a_run_halt_lamps: assert property (lamps.run_lamp != lamps.halt_lamp)
        else $error("run and halt lamps not exclusive");
    a_run_lamp_held: assert property (lamps.run_lamp && !panel.halt_press && !$past(panel.halt_press)
        && !$past(panel.halt_press, 2) && !$past(panel.halt_press, 3) && !$past(panel.halt_press, 4)
        |=> lamps.run_lamp) else $error("run lamp dropped without halt");
    a_halt_lamp_on: assert property ($rose(panel.halt_press) |-> ##[1:6] lamps.halt_lamp)
        else $error("halt press did not light halt lamp");
    a_run_start: assert property ($rose(panel.run_press) && !panel.halt_press && !busy |-> ##[1:6] busy)
        else $error("run press did not start");
    a_trig_start: assert property ($rose(panel.contact_closure_trigger_input) && !busy |-> ##[1:6] busy)
        else $error("trigger did not start");
    a_step_busy: assert property (step_pulse |-> busy)
        else $error("step while idle");
    a_step_gap: assert property (step_pulse |=> !step_pulse [*8])
        else $error("steps faster than top speed");
    a_stall_run: assert property ($rose(stall_fault) |-> $past(busy))
        else $error("stall raised while idle");
endmodule

bind mpds_top mpds_monitor #(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) u_mon (
    .clk(clk), .rst(rst), .panel(panel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_pulse(step_pulse),
    .motor_dir(motor_dir), .lamps(lamps), .stall_fault(stall_fault), .busy(busy));

// >>> dv/mpds_pump_model.sv
// Behavioural pump head: one revolution per REV_STEPS steps, spindle sensor pulse per turn.
// Assumes step_pulse is a one-cycle pulse on clk; counts turns by direction.
`timescale 1ns/1ps
module mpds_pump_model #(
    parameter int REV_STEPS = 200
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic step_pulse,
    input  wire logic motor_dir,
    output logic      spindle_pulse,
    output int        fwd_revs,
    output int        rev_revs
);
    int pos;
    int hold;
    always @(posedge clk) begin
        if (rst) begin
            pos <= 0;
            hold <= 0;
            fwd_revs <= 0;
            rev_revs <= 0;
        end else begin
            if (hold > 0) begin
                hold <= hold - 1;
            end
            if (step_pulse && pos == REV_STEPS - 1) begin
                pos <= 0;
                hold <= 4;
                if (motor_dir) begin
                    rev_revs <= rev_revs + 1;
                end else begin
                    fwd_revs <= fwd_revs + 1;
                end
            end else if (step_pulse) begin
                pos <= pos + 1;
            end
        end
    end
    // Sensor pulse wide enough to pass the pin synchronisers
    assign spindle_pulse = (hold > 0);
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the dispense sequencer with a behavioural pump head.
// Assumes ramps shortened to 4 cycles per count and two steps per pump turn.
`timescale 1ns/1ps
module tb_top;
    import mpds_pkg::*;
    localparam int P_CONT = 10;
    localparam int P_DIR  = 9;
    localparam int P_RET  = 8;
    localparam int P_RUN  = 7;
    localparam int P_HALT = 6;
    localparam int P_CP   = 5;
    localparam int P_CM   = 4;
    localparam int P_SP   = 3;
    localparam int P_SM   = 2;
    localparam int P_TRIG = 1;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic [10:0] pin       = 11'h000;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic        step_pulse;
    logic        motor_dir;
    logic        stall_fault;
    logic        busy;
    logic        spindle;
    mpds_panel_t panel;
    mpds_lamp_t  lamps;
    int          fwd_revs;
    int          rev_revs;
    int          err_count       = 0;
    int          samples_checked = 0;

    always #12.5 clk = ~clk;
    assign panel = {pin[10:1], spindle};

    mpds_top #(.RAMP_TICK_CYCLES(4)) dut (.clk(clk), .rst(rst), .panel(panel), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .step_pulse(step_pulse), .motor_dir(motor_dir), .lamps(lamps), .stall_fault(stall_fault), .busy(busy));
    mpds_pump_model #(.REV_STEPS(2)) u_pump (.clk(clk), .rst(rst), .step_pulse(step_pulse),
        .motor_dir(motor_dir), .spindle_pulse(spindle), .fwd_revs(fwd_revs), .rev_revs(rev_revs));

    task automatic end_sim;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, exp);
    endtask

    // Pins pass two sync flops, so hold and gap span several edges
    task automatic press(input int idx);
        @(posedge clk);
        pin[idx] <= 1'b1;
        repeat (3) @(posedge clk);
        pin[idx] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_busy(input logic lvl, input int max);
        int n;
        n = 0;
        while (busy !== lvl && n < max) begin
            @(posedge clk);
            n++;
        end
        chk(busy, lvl);
    endtask

    task automatic t_reset;
        repeat (4) @(posedge clk);
        chk(lamps, 8'ha9);
        chk({busy, stall_fault, step_pulse}, 3'h0);
        reg_check(4'h3, 16'h0001);
        reg_check(4'h4, 16'h01f4);
        reg_check(4'h9, 16'h0000);
    endtask

    task automatic t_settings;
        repeat (2) press(P_CM);
        reg_check(4'h3, 16'h0000);
        press(P_CP);
        reg_check(4'h3, 16'h0001);
        repeat (500) press(P_SP);
        reg_check(4'h4, 16'h03e7);
        reg_write(4'h4, 16'h0005);
        reg_check(4'h4, 16'h03e7);
        press(P_SM);
        reg_check(4'h4, 16'h03e6);
    endtask

    task automatic t_lamps;
        @(posedge clk);
        pin[P_CONT] <= 1'b1;
        pin[P_DIR] <= 1'b1;
        pin[P_RET] <= 1'b1;
        repeat (5) @(posedge clk);
        chk(lamps, 8'h55);
        pin[P_CONT] <= 1'b0;
        pin[P_DIR] <= 1'b0;
        repeat (5) @(posedge clk);
        chk(lamps, 8'ha5);
    endtask

    // Count of one with retract: one forward turn, then one reverse turn
    task automatic t_dispense;
        @(posedge clk);
        pin[P_TRIG] <= 1'b1;
        wait_busy(1'b1, 10);
        chk(lamps.run_lamp, 1'b1);
        wait_busy(1'b0, 80000);
        chk({fwd_revs[7:0], rev_revs[7:0]}, 16'h0101);
        repeat (20) @(posedge clk);
        chk(busy, 1'b0);
        chk(lamps.run_lamp, 1'b1);
        reg_write(4'h0, 16'h0001);
        chk(stall_fault, 1'b0);
        pin[P_TRIG] <= 1'b0;
    endtask

    task automatic t_continuous;
        int rev_before;
        @(posedge clk);
        pin[P_CONT] <= 1'b1;
        pin[P_DIR] <= 1'b1;
        repeat (5) @(posedge clk);
        press(P_RUN);
        wait_busy(1'b1, 4);
        chk({motor_dir, lamps.continuous_lamp, lamps.run_lamp}, 3'h7);
        repeat (16000) @(posedge clk);
        chk(busy, 1'b1);
        reg_check(4'h2, 16'h0000);
        rev_before = rev_revs;
        press(P_HALT);
        chk({lamps.run_lamp, lamps.halt_lamp}, 2'h1);
        wait_busy(1'b0, 5000);
        chk(rev_revs, rev_before);
    endtask

    initial begin
        repeat (98000) @(posedge clk);
        err_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_settings();
        t_lamps();
        t_dispense();
        t_continuous();
        end_sim();
    end
endmodule
